//--- hw/mbm_pkg.sv
// constants and types shared by the memory bank address map
package mbm_pkg;

  // program side
  localparam int PC_W = 13;
  localparam int LATCH_W = 8;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] PROG_MASK_2K = 13'h07FF;
  localparam logic [12:0] PROG_MASK_4K = 13'h0FFF;
  localparam logic [12:0] PROG_MASK_8K = 13'h1FFF;

  // program memory variants: 2K, 4K and 8K words
  localparam int VARIANT_SMALL = 0;
  localparam int VARIANT_MID = 1;
  localparam int VARIANT_LARGE = 2;

  // data side: 9-bit address = bank(2) & offset(7)
  localparam int DADDR_W = 9;
  localparam int OFFSET_W = 7;
  localparam int GPR_DEPTH = 368;

  // core special function register offsets, present in every bank
  localparam logic [6:0] IDX_INDIRECT = 7'h00;
  localparam logic [6:0] IDX_PCL = 7'h02;
  localparam logic [6:0] IDX_STATUS = 7'h03;
  localparam logic [6:0] IDX_POINTER = 7'h04;
  localparam logic [6:0] IDX_UPPER_LATCH = 7'h0A;

  // core status word fields
  localparam int ST_INDIRECT_BANK_BIT = 7;
  localparam int ST_BANK_HIGH_BIT = 6;
  localparam int ST_BANK_LOW_BIT = 5;

  // general purpose storage layout
  localparam logic [6:0] GPR_LO = 7'h20;
  localparam logic [6:0] GPR_HI_LO = 7'h10;
  localparam logic [6:0] COMMON_LO = 7'h70;
  localparam logic [6:0] BANK1_TOP_SMALL = 7'h3F;
  localparam logic [6:0] BANK1_TOP_MID = 7'h7F;
  localparam logic [6:0] BANK1_TOP_LARGE = 7'h6F;
  localparam logic [8:0] GPR_BASE_BANK1 = 9'h060;
  localparam logic [8:0] GPR_BASE_BANK2 = 9'h0B0;
  localparam logic [8:0] GPR_BASE_BANK3 = 9'h110;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  // apb map: word index = data address, byte address = 4 * index
  localparam int PADDR_W = 12;
  localparam int APB_INDEX_LSB = 2;

  typedef enum logic {
    MBM_AP_IDLE = 1'b0,
    MBM_AP_ANSWER = 1'b1
  } mbm_apb_state_t;

endpackage : mbm_pkg

//--- hw/mbm_top.sv
// memory bank address map: program counter, vectors, banked data space
//
// Our own choice: register access over APB.
`timescale 1ns/10ps

module mbm_top #(
  parameter int VARIANT = mbm_pkg::VARIANT_LARGE
) (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu fetch path
  input wire logic fetch_next,
  input wire logic fetch_jump,
  input wire logic [10:0] jump_target,
  input wire logic irq_take,
  output logic [12:0] fetch_addr,
  // cpu data path
  input wire logic data_req,
  input wire logic data_we,
  input wire logic data_indirect,
  input wire logic [6:0] data_offset,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  output logic data_ack,
  output logic [1:0] bank_select
);

  // one packed record holds every flop of the block except the storage array
  typedef struct packed {
    logic [12:0] pc;
    logic [7:0] latch;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [12:0] fetch_addr;
    logic [7:0] data_rdata;
    logic data_ack;
    logic [7:0] prdata;
    logic pready;
    logic pslverr;
    mbm_pkg::mbm_apb_state_t ap;
  } mbm_state_t;

  // fetch reach and the top of bank 1 storage follow the fitted variant
  localparam logic [12:0] PROG_MASK =
    (VARIANT == mbm_pkg::VARIANT_SMALL) ? mbm_pkg::PROG_MASK_2K :
    (VARIANT == mbm_pkg::VARIANT_MID) ? mbm_pkg::PROG_MASK_4K :
    mbm_pkg::PROG_MASK_8K;
  localparam logic [6:0] BANK1_TOP =
    (VARIANT == mbm_pkg::VARIANT_SMALL) ? mbm_pkg::BANK1_TOP_SMALL :
    (VARIANT == mbm_pkg::VARIANT_MID) ? mbm_pkg::BANK1_TOP_MID :
    mbm_pkg::BANK1_TOP_LARGE;

  // all state but the storage array sits in one register; st_d is its next value
  mbm_state_t st_q;
  mbm_state_t st_d;

  // general purpose storage, no reset: contents are undefined at power-up
  logic [7:0] gpr_mem [mbm_pkg::GPR_DEPTH];
  // single write port into the storage array
  logic gpr_we;
  logic [8:0] gpr_widx;
  logic [7:0] gpr_wdata;

  // map a data address to {hit, storage index}; miss reads as zero
  function automatic logic [9:0] gpr_map(input logic [8:0] a);
    logic [1:0] b;
    logic [6:0] o;
    // split into bank number and offset within the bank
    b = a[8:7];
    o = a[6:0];
    gpr_map = 10'h000;
    if (b == 2'h0 && o >= mbm_pkg::GPR_LO) begin
      // bank 0 storage sits just above the special registers
      gpr_map = {1'b1, 2'h0, 7'(o - mbm_pkg::GPR_LO)};
    end else if (VARIANT != mbm_pkg::VARIANT_MID &&
                 o >= mbm_pkg::COMMON_LO) begin
      // on the small and large variants the top of banks 1 to 3 falls on the same bytes as bank 0
      gpr_map = {1'b1, 2'h0, 7'(o - mbm_pkg::GPR_LO)};
    end else if (b == 2'h1 && o >= mbm_pkg::GPR_LO &&
                 o <= BANK1_TOP) begin
      // bank 1 storage stops short of the shared top on two variants
      gpr_map = {1'b1, 9'(mbm_pkg::GPR_BASE_BANK1 +
                          {2'h0, 7'(o - mbm_pkg::GPR_LO)})};
    end else if (VARIANT == mbm_pkg::VARIANT_LARGE && b[1] &&
                 o >= mbm_pkg::GPR_HI_LO) begin
      // only the large variant fits storage in banks 2 and 3
      gpr_map = {1'b1, 9'((b[0] ? mbm_pkg::GPR_BASE_BANK3 :
                                  mbm_pkg::GPR_BASE_BANK2) +
                          {2'h0, 7'(o - mbm_pkg::GPR_HI_LO)})};
    end
  endfunction : gpr_map

  // the indirect port stands for the location the pointer names
  function automatic logic [8:0] resolve(input logic [8:0] a,
                                         input mbm_state_t s);
    // any other offset is taken as it stands
    resolve = a;
    if (a[6:0] == mbm_pkg::IDX_INDIRECT) begin
      resolve = {s.status[mbm_pkg::ST_INDIRECT_BANK_BIT], s.pointer};
    end
  endfunction : resolve

  // read one byte of the data space, shared by cpu and apb
  function automatic logic [7:0] read_data(input logic [8:0] a,
                                           input mbm_state_t s);
    logic [8:0] r;
    logic [9:0] m;
    r = resolve(a, s);
    m = gpr_map(r);
    read_data = 8'h00;
    // core registers first, then storage; the rest reads as zero
    unique case (r[6:0])
      // indirect through the pointer onto the port itself yields zero
      mbm_pkg::IDX_INDIRECT: read_data = 8'h00;
      mbm_pkg::IDX_PCL: read_data = s.pc[7:0];
      mbm_pkg::IDX_STATUS: read_data = s.status;
      mbm_pkg::IDX_POINTER: read_data = s.pointer;
      mbm_pkg::IDX_UPPER_LATCH: read_data = s.latch;
      default: begin
        // storage, or zero where nothing is fitted
        if (m[9]) begin
          read_data = gpr_mem[m[8:0]];
        end
      end
    endcase
  endfunction : read_data

  // effective cpu address: pointer or bank bits over offset
  logic [8:0] cpu_addr;
  logic [8:0] apb_addr;
  logic apb_in_range;
  assign cpu_addr = data_indirect ?
    {st_q.status[mbm_pkg::ST_INDIRECT_BANK_BIT], st_q.pointer} :
    {st_q.status[mbm_pkg::ST_BANK_HIGH_BIT],
     st_q.status[mbm_pkg::ST_BANK_LOW_BIT], data_offset};
  // apb word index is the 9-bit data address, bank bits included
  assign apb_addr = paddr[mbm_pkg::APB_INDEX_LSB +: mbm_pkg::DADDR_W];
  // only word-aligned addresses inside the 512-word window are served
  assign apb_in_range = (paddr[11:11] == 1'b0) &&
                        (paddr[1:0] == 2'b00);

  // next state: apb handshake, cpu data access, program counter
  always_comb begin
    logic wr;
    logic [8:0] wa;
    logic [7:0] wd;
    logic [8:0] wr_res;
    logic [9:0] wm;
    logic pcl_wr;
    logic apb_commit;
    wr = 1'b0;
    wa = 9'h000;
    wd = 8'h00;
    wr_res = 9'h000;
    wm = 10'h000;
    pcl_wr = 1'b0;
    apb_commit = 1'b0;
    // hold everything by default; pulses fall back to zero
    st_d = st_q;
    st_d.data_ack = 1'b0;
    gpr_we = 1'b0;
    gpr_widx = 9'h000;
    gpr_wdata = 8'h00;

    // apb: answer one cycle into the access phase, commit on handshake
    unique case (st_q.ap)
      mbm_pkg::MBM_AP_IDLE: begin
        // cpu has the port this cycle; apb waits with pready low
        if (psel && penable && !data_req) begin
          // misaligned or out-of-range words answer with an error
          st_d.prdata = apb_in_range ? read_data(apb_addr, st_q) : 8'h00;
          st_d.pslverr = !apb_in_range;
          st_d.pready = 1'b1;
          st_d.ap = mbm_pkg::MBM_AP_ANSWER;
        end
      end
      mbm_pkg::MBM_AP_ANSWER: begin
        // the master samples pready here, so the write lands now
        apb_commit = pwrite && apb_in_range;
        // a refused write leaves every register and byte untouched
        // pready stands for one cycle only
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        st_d.ap = mbm_pkg::MBM_AP_IDLE;
      end
    endcase

    // one write port: apb commit first, cpu retries next cycle
    if (apb_commit) begin
      wr = 1'b1;
      wa = apb_addr;
      wd = pwdata[7:0];
    end else if (data_req && !st_q.data_ack) begin
      // the ack cycle is the tail of the request just served; taking it
      // again would repeat the access while the core still holds it
      st_d.data_ack = 1'b1;
      st_d.data_rdata = read_data(cpu_addr, st_q);
      wr = data_we;
      wa = cpu_addr;
      wd = data_wdata;
    end

    // write decode into core registers or storage
    // core registers decode at the same offset in every bank
    wr_res = resolve(wa, st_q);
    wm = gpr_map(wr_res);
    if (wr) begin
      unique case (wr_res[6:0])
        mbm_pkg::IDX_INDIRECT: ; // pointer back onto the port: no effect
        mbm_pkg::IDX_PCL: pcl_wr = 1'b1;
        mbm_pkg::IDX_STATUS: st_d.status = wd;
        mbm_pkg::IDX_POINTER: st_d.pointer = wd;
        mbm_pkg::IDX_UPPER_LATCH: st_d.latch = wd;
        default: begin
          // storage bytes, or nothing where the map misses
          gpr_we = wm[9];
          gpr_widx = wm[8:0];
          gpr_wdata = wd;
        end
      endcase
    end

    // program counter: interrupt beats a counter write beats a jump
    if (irq_take) begin
      st_d.pc = mbm_pkg::IRQ_VECTOR;
    end else if (pcl_wr) begin
      // a counter write takes its upper bits from the latch
      st_d.pc = {st_q.latch[4:0], wd};
    end else if (fetch_jump) begin
      // a jump keeps two latch bits above the 11-bit target
      st_d.pc = {st_q.latch[4:3], jump_target};
    end else if (fetch_next) begin
      st_d.pc = 13'(st_q.pc + 13'h0001);
    end
    // upper bits beyond the fitted memory are dropped, so fetches wrap
    st_d.fetch_addr = st_d.pc & PROG_MASK;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.pc <= mbm_pkg::RESET_VECTOR;
      st_q.latch <= mbm_pkg::LATCH_RESET;
      st_q.status <= mbm_pkg::STATUS_RESET;
      st_q.pointer <= mbm_pkg::POINTER_RESET;
      st_q.fetch_addr <= mbm_pkg::RESET_VECTOR;
      st_q.data_rdata <= 8'h00;
      st_q.data_ack <= 1'b0;
      st_q.prdata <= 8'h00;
      st_q.pready <= 1'b0;
      st_q.pslverr <= 1'b0;
      st_q.ap <= mbm_pkg::MBM_AP_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // storage write port; reads are combinational from the array
  // no reset here keeps the array a plain ram; contents start unknown
  always_ff @(posedge pclk) begin
    if (gpr_we) begin
      gpr_mem[gpr_widx] <= gpr_wdata;
    end
  end

  // outputs straight from the state register
  // upper read lanes stay zero: each word carries one byte
  assign prdata = {24'h000000, st_q.prdata};
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign fetch_addr = st_q.fetch_addr;
  assign data_rdata = st_q.data_rdata;
  assign data_ack = st_q.data_ack;
  assign bank_select = {st_q.status[mbm_pkg::ST_BANK_HIGH_BIT],
                        st_q.status[mbm_pkg::ST_BANK_LOW_BIT]};

endmodule : mbm_top

//--- dv/mbm_props.sv
// assertion checker for the memory bank address map ports
`timescale 1ns/10ps
module mbm_props #(
  parameter int VARIANT = mbm_pkg::VARIANT_LARGE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fetch_next,
  input wire logic fetch_jump,
  input wire logic [10:0] jump_target,
  input wire logic irq_take,
  input wire logic [12:0] fetch_addr,
  input wire logic data_req,
  input wire logic data_we,
  input wire logic data_indirect,
  input wire logic [6:0] data_offset,
  input wire logic [7:0] data_wdata,
  input wire logic [7:0] data_rdata,
  input wire logic data_ack,
  input wire logic [1:0] bank_select
);
  // fetch reach depends on the program memory size of the variant
  localparam logic [12:0] MASK = (VARIANT == 0) ? mbm_pkg::PROG_MASK_2K :
    (VARIANT == 1) ? mbm_pkg::PROG_MASK_4K : mbm_pkg::PROG_MASK_8K;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reset_fetch_start: assert property (
    $rose(presetn) |-> fetch_addr == 13'h0000) else $error("no reset fetch");
  a_irq_vector: assert property (
    irq_take |-> ##[1:2] fetch_addr == 13'h0004) else $error("bad irq fetch");
  a_fetch_in_range: assert property (
    (fetch_addr & ~MASK) == 13'h0000) else $error("fetch beyond memory");
  // bank bits only move when a write has just been answered
  a_bank_follow: assert property (
    $changed(bank_select) |-> data_ack || pready || $past(data_ack) ||
    $past(pready)) else $error("bank select moved alone");
  a_data_answer: assert property (
    $rose(data_req) |-> ##[1:2] data_ack) else $error("data access late");
  a_ack_cause: assert property (
    data_ack |-> $past(data_req)) else $error("ack without request");
  a_range_error: assert property (
    pready && paddr[11] |-> pslverr && prdata == 32'h0000_0000)
    else $error("out of range not refused");
  a_byte_lane: assert property (
    pready |-> prdata[31:8] == 24'h00_0000) else $error("upper lanes set");
  a_unimpl_zero: assert property (
    data_ack && !data_we && !data_indirect && data_offset == 7'h01 |->
    data_rdata == 8'h00) else $error("unimplemented read not zero");
endmodule : mbm_props

bind mbm_top mbm_props #(.VARIANT(VARIANT)) u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .fetch_next, .fetch_jump, .jump_target, .irq_take, .fetch_addr,
  .data_req, .data_we, .data_indirect, .data_offset, .data_wdata,
  .data_rdata, .data_ack, .bank_select);

//--- dv/mbm_cpu_model.sv
// behavioural cpu core driving the fetch and data paths
`timescale 1ns/10ps
module mbm_cpu_model (
  input wire logic pclk,
  output logic fetch_next,
  output logic fetch_jump,
  output logic [10:0] jump_target,
  output logic irq_take,
  output logic data_req,
  output logic data_we,
  output logic data_indirect,
  output logic [6:0] data_offset,
  output logic [7:0] data_wdata,
  input wire logic [7:0] data_rdata,
  input wire logic data_ack
);
  bit late = 1'b0;

  // idle core at time zero
  initial begin
    {fetch_next, fetch_jump, irq_take, data_req} = 4'h0;
    {data_we, data_indirect, jump_target} = 13'h0000;
    data_offset = 7'h00;
    data_wdata = 8'h00;
  end

  // one data access, request held until the ack edge
  task automatic access(input logic we, input logic ind,
                        input logic [6:0] off, input logic [7:0] wd,
                        output logic [7:0] rd);
    int n;
    n = 0;
    data_req <= 1'b1;
    data_we <= we;
    data_indirect <= ind;
    data_offset <= off;
    data_wdata <= wd;
    do begin
      @(posedge pclk);
      n++;
    end while (data_ack !== 1'b1 && n < 50);
    late = (n >= 50);
    rd = data_rdata;
    data_req <= 1'b0;
    // released bus shows no stale value
    data_offset <= ~off;
    data_wdata <= ~wd;
    // one idle edge so the next request never reuses this time step
    @(posedge pclk);
  endtask : access

  // one-cycle fetch pulse: 0 next, 1 jump, 2 interrupt
  task automatic pulse(input int k, input logic [10:0] t);
    jump_target <= t;
    fetch_next <= (k == 0);
    fetch_jump <= (k == 1);
    irq_take <= (k == 2);
    @(posedge pclk);
    {fetch_next, fetch_jump, irq_take} <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask : pulse
endmodule : mbm_cpu_model

//--- dv/tb.sv
// self-checking bench for the memory bank address map
`timescale 1ns/10ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, fetch_next, fetch_jump, irq_take;
  logic data_req, data_we, data_indirect, data_ack;
  logic [10:0] jump_target;
  logic [12:0] fetch_addr;
  logic [6:0] data_offset;
  logic [7:0] data_wdata, data_rdata, cd;
  logic [1:0] bank_select;
  logic [12:0] fetch_mid, fetch_big;
  logic [11:0] regs[3] = '{12'h00C, 12'h010, 12'h028};
  int n_mismatch = 0;
  int checks = 0;

  always #20 pclk = ~pclk;

  // small variant so the 2K fetch wrap is reachable
  mbm_top #(.VARIANT(mbm_pkg::VARIANT_SMALL)) uut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .fetch_next, .fetch_jump, .jump_target, .irq_take, .fetch_addr,
    .data_req, .data_we, .data_indirect, .data_offset, .data_wdata,
    .data_rdata, .data_ack, .bank_select);
  // wider variants see the same stimulus; only their fetch path is compared
  mbm_top #(.VARIANT(mbm_pkg::VARIANT_MID)) uut_mid (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(),
    .pslverr(), .fetch_next, .fetch_jump, .jump_target, .irq_take,
    .fetch_addr(fetch_mid), .data_req, .data_we, .data_indirect,
    .data_offset, .data_wdata, .data_rdata(), .data_ack(), .bank_select());
  mbm_top #(.VARIANT(mbm_pkg::VARIANT_LARGE)) uut_big (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(),
    .pslverr(), .fetch_next, .fetch_jump, .jump_target, .irq_take,
    .fetch_addr(fetch_big), .data_req, .data_we, .data_indirect,
    .data_offset, .data_wdata, .data_rdata(), .data_ack(), .bank_select());
  mbm_cpu_model cpu (.pclk, .fetch_next, .fetch_jump, .jump_target,
    .irq_take, .data_req, .data_we, .data_indirect, .data_offset,
    .data_wdata, .data_rdata, .data_ack);

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // apb transfer: setup, then access until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // an idle edge keeps psel from being driven twice in one step
    @(posedge pclk);
    if (n >= 50) begin
      n_mismatch++;
      results();
    end
  endtask : apb

  // cpu data access; a hung ack ends the run
  task automatic da(input logic we, input logic ind, input logic [6:0] off,
                    input logic [7:0] wd);
    cpu.access(we, ind, off, wd, cd);
    if (cpu.late) begin
      n_mismatch++;
      results();
    end
  endtask : da

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("fetch_reset", fetch_addr, 13'h0000);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0, rd);
      chk("reg_reset", rd, 32'h0000_0000);
    end
    // storage in bank 0, then a hole of the small variant in bank 1
    apb(1'b1, 12'h080, 32'h0000_00A5, rd);
    apb(1'b1, 12'h300, 32'h0000_003C, rd);
    apb(1'b0, 12'h080, 32'h0, rd);
    chk("gpr_bank0", rd, 32'h0000_00A5);
    apb(1'b0, 12'h300, 32'h0, rd);
    chk("gpr_hole", rd, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0, rd);
    chk("periph_zero", rd, 32'h0000_0000);
    apb(1'b0, 12'h800, 32'h0, rd);
    chk("range_zero", rd, 32'h0000_0000);
    // status is reached from every bank and drives the bank bits
    for (int b = 0; b < 4; b++) begin
      da(1'b1, 1'b0, 7'h03, {1'b0, b[1:0], 5'h00});
      @(posedge pclk);
      chk("bank_sel", bank_select, b[1:0]);
      da(1'b0, 1'b0, 7'h03, 8'h00);
      chk("status_mirror", cd, {1'b0, b[1:0], 5'h00});
    end
    da(1'b1, 1'b0, 7'h03, 8'h20);
    da(1'b1, 1'b0, 7'h20, 8'h5A);
    apb(1'b0, 12'h280, 32'h0, rd);
    chk("direct_addr", rd, 32'h0000_005A);
    da(1'b0, 1'b0, 7'h01, 8'h00);
    chk("cpu_unimpl", cd, 8'h00);
    // pointer based access lands where the pointer says
    da(1'b1, 1'b0, 7'h04, 8'h21);
    da(1'b1, 1'b1, 7'h55, 8'hC3);
    apb(1'b0, 12'h084, 32'h0, rd);
    chk("indirect_wr", rd, 32'h0000_00C3);
    da(1'b0, 1'b0, 7'h00, 8'h00);
    chk("indirect_port", cd, 8'hC3);
    // fetch stepping, jump with latch bits, wrap and interrupt
    cpu.pulse(0, 11'h000);
    chk("fetch_step", fetch_addr, 13'h0001);
    da(1'b1, 1'b0, 7'h0A, 8'h08);
    cpu.pulse(1, 11'h7FE);
    chk("fetch_jump", fetch_addr, 13'h07FE);
    chk("jump_mid", fetch_mid, 13'h0FFE);
    chk("jump_big", fetch_big, 13'h0FFE);
    cpu.pulse(0, 11'h000);
    chk("fetch_top", fetch_addr, 13'h07FF);
    chk("top_mid", fetch_mid, 13'h0FFF);
    chk("top_big", fetch_big, 13'h0FFF);
    cpu.pulse(0, 11'h000);
    chk("fetch_wrap", fetch_addr, 13'h0000);
    chk("wrap_mid", fetch_mid, 13'h0000);
    chk("reach_big", fetch_big, 13'h1000);
    cpu.pulse(2, 11'h000);
    chk("fetch_irq", fetch_addr, 13'h0004);
    da(1'b1, 1'b0, 7'h02, 8'h10);
    repeat (3) @(posedge pclk);
    chk("pc_low_load", fetch_addr, 13'h0010);
    chk("pc_load_mid", fetch_mid, 13'h0810);
    chk("pc_load_big", fetch_big, 13'h0810);
    // a second reset mid-run restarts fetching and clears the bank bits
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("fetch_rerun", fetch_addr, 13'h0000);
    chk("bank_rerun", bank_select, 2'h0);
    results();
  end
endmodule : tb
